// ### pmic_regs_pkg.sv
package pmic_regs_pkg;

	// ***************************************************
	// register map
	// ***************************************************
	localparam logic [7:0] ADDR_TOP_WO = 8'h0D;
	localparam logic [7:0] ADDR_CHG_PRI = 8'h10;
	localparam logic [7:0] ADDR_CHG_SEC = 8'h11;

	// ***************************************************
	// field layout and codes
	// ***************************************************
	localparam int WD_LSB = 0;
	localparam int WD_MSB = 2;
	localparam logic [2:0] WD_RESTART_CODE = 3'h1;
	localparam int KEY_LSB = 3;
	localparam int KEY_MSB = 7;
	localparam logic [4:0] KEY_UNLOCK = 5'h15;
	localparam int THERM_BIT = 2;
	localparam int TIMERS_BIT = 1;
	localparam int CHGEN_BIT = 0;

	// ***************************************************
	// reset values
	// ***************************************************
	localparam logic [7:0] PRI_RESET = 8'h02;
	localparam logic [7:0] SEC_RESET = 8'h08;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [1:0] SYNC_RESET = 2'h3;

	// ***************************************************
	// serial slave
	// ***************************************************
	// bus address value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_DEV = 7'h02,
		S_ACK = 7'h04,
		S_PTR = 7'h08,
		S_WR = 7'h10,
		S_RD = 7'h20,
		S_MACK = 7'h40
	} state_t;

endpackage : pmic_regs_pkg

// ### pin_sync.sv
`timescale 1ns/1ns
module pin_sync (
	// clock and control
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// pins
	input wire logic [1:0] pin_in,
	output logic [1:0] pin_out
);

	logic [1:0] meta_q;
	logic [1:0] meta_d;
	logic [1:0] sync_q;
	logic [1:0] sync_d;

	// ***************************************************
	// two-stage synchroniser
	// ***************************************************
	always_comb begin
		meta_d = pin_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= pmic_regs_pkg::SYNC_RESET;
			sync_q <= pmic_regs_pkg::SYNC_RESET;
		end else if (ce) begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign pin_out = sync_q;

endmodule : pin_sync

// ### pmic_watchdog_charger_ctrl_regs.sv
// Function
// - register 0Dh is write-only, reads zero
// - writing 001 restarts the watchdog
// - other codes leave watchdog undisturbed
// - key 10101 opens protected registers
// - other key values make protected writes ignored
// - register 10h read/write with key, enables
// - bit 2 thermistor control, resets 0
// - bit 1 both charge timers, resets 1
// - bit 0 charger enable, strap reset
// - register 11h read/write, locked, all 8 bits stored
`timescale 1ns/1ns
module pmic_watchdog_charger_ctrl_regs (
	// clock, reset, enable
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic CE,
	// serial bus pins
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// nonvolatile default
	input wire logic CHARGER_ENABLE_DEFAULT,
	// controls
	output logic WATCHDOG_RESTART,
	output logic CHARGER_ENABLE,
	output logic CHARGE_TIMERS_ENABLE,
	output logic THERMISTOR_CONTROL_ENABLE,
	output logic [7:0] CHARGER_CONTROL_SECONDARY
);

	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic scl_p_q, scl_p_d;
	logic sda_p_q, sda_p_d;
	pmic_regs_pkg::state_t state_q, state_d;
	pmic_regs_pkg::state_t nxt_q, nxt_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic [7:0] ptr_q, ptr_d;
	logic oe_q, oe_d;
	logic ack_ok_q, ack_ok_d;
	logic [7:0] prim_q, prim_d;
	logic [7:0] sec_q, sec_d;
	logic wd_q, wd_d;
	logic sda_o_q;
	logic [7:0] rdata;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic wr_fire;
	logic key_open;

	// ***************************************************
	// pin synchronisers
	// ***************************************************
	pin_sync u_sync (
		.clk(CLK_SYS),
		.srst(SRST),
		.ce(CE),
		.pin_in({SCL_I, SDA_I}),
		.pin_out(pins_s)
	);
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// ***************************************************
	// read mux
	// ***************************************************
	always_comb begin
		unique case (ptr_q)
			pmic_regs_pkg::ADDR_CHG_PRI: rdata = prim_q;
			pmic_regs_pkg::ADDR_CHG_SEC: rdata = sec_q;
			default: rdata = pmic_regs_pkg::READ_ZERO;
		endcase
	end

	assign key_open = prim_q[pmic_regs_pkg::KEY_MSB:pmic_regs_pkg::KEY_LSB]
		== pmic_regs_pkg::KEY_UNLOCK;

	// ***************************************************
	// bus slave and register next state
	// ***************************************************
	always_comb begin
		scl_rise = scl_s & ~scl_p_q;
		scl_fall = ~scl_s & scl_p_q;
		start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
		stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
		scl_p_d = scl_s;
		sda_p_d = sda_s;
		state_d = state_q;
		nxt_d = nxt_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		ack_ok_d = ack_ok_q;
		prim_d = prim_q;
		sec_d = sec_q;
		wd_d = 1'b0;
		wr_fire = 1'b0;
		if (start_c) begin
			state_d = pmic_regs_pkg::S_DEV;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (stop_c) begin
			state_d = pmic_regs_pkg::S_IDLE;
			oe_d = 1'b0;
		end else begin
			unique case (state_q)
				pmic_regs_pkg::S_IDLE: begin end
				pmic_regs_pkg::S_DEV,
				pmic_regs_pkg::S_PTR,
				pmic_regs_pkg::S_WR: begin
					if (scl_rise && cnt_q < pmic_regs_pkg::BITS_PER_BYTE) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall &&
						cnt_q == pmic_regs_pkg::BITS_PER_BYTE) begin
						state_d = pmic_regs_pkg::S_ACK;
						oe_d = 1'b1;
						if (state_q == pmic_regs_pkg::S_DEV) begin
							if (sh_q[7:1] == pmic_regs_pkg::DEV_ADDR) begin
								nxt_d = sh_q[0] ? pmic_regs_pkg::S_RD
									: pmic_regs_pkg::S_PTR;
							end else begin
								state_d = pmic_regs_pkg::S_IDLE;
								oe_d = 1'b0;
							end
						end else if (state_q == pmic_regs_pkg::S_PTR) begin
							ptr_d = sh_q;
							nxt_d = pmic_regs_pkg::S_WR;
						end else begin
							wr_fire = CE;
							ptr_d = ptr_q + 8'h01;
							nxt_d = pmic_regs_pkg::S_WR;
							if (ptr_q == pmic_regs_pkg::ADDR_TOP_WO) begin
								wd_d = sh_q[pmic_regs_pkg::WD_MSB:pmic_regs_pkg::WD_LSB]
									== pmic_regs_pkg::WD_RESTART_CODE;
							end else if (ptr_q == pmic_regs_pkg::ADDR_CHG_PRI) begin
								prim_d = sh_q;
							end else if (ptr_q == pmic_regs_pkg::ADDR_CHG_SEC) begin
								if (key_open) begin
									sec_d = sh_q;
								end
							end
						end
					end
				end
				pmic_regs_pkg::S_ACK: begin
					if (scl_fall) begin
						oe_d = 1'b0;
						cnt_d = 4'h0;
						state_d = nxt_q;
						if (nxt_q == pmic_regs_pkg::S_RD) begin
							tx_d = rdata;
							oe_d = ~rdata[7];
						end
					end
				end
				pmic_regs_pkg::S_RD: begin
					if (scl_fall) begin
						if (cnt_q == pmic_regs_pkg::LAST_TX_BIT) begin
							oe_d = 1'b0;
							cnt_d = 4'h0;
							state_d = pmic_regs_pkg::S_MACK;
						end else begin
							tx_d = {tx_q[6:0], 1'b0};
							oe_d = ~tx_q[6];
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				pmic_regs_pkg::S_MACK: begin
					if (scl_rise) begin
						ack_ok_d = ~sda_s;
						if (~sda_s) begin
							ptr_d = ptr_q + 8'h01;
						end
					end else if (scl_fall) begin
						if (ack_ok_q) begin
							state_d = pmic_regs_pkg::S_RD;
							tx_d = rdata;
							oe_d = ~rdata[7];
						end else begin
							state_d = pmic_regs_pkg::S_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			state_q <= pmic_regs_pkg::S_IDLE;
			nxt_q <= pmic_regs_pkg::S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
			ack_ok_q <= 1'b0;
			prim_q <= {pmic_regs_pkg::PRI_RESET[7:1], CHARGER_ENABLE_DEFAULT};
			sec_q <= pmic_regs_pkg::SEC_RESET;
			wd_q <= 1'b0;
			sda_o_q <= 1'b0;
		end else if (CE) begin
			scl_p_q <= scl_p_d;
			sda_p_q <= sda_p_d;
			state_q <= state_d;
			nxt_q <= nxt_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
			ack_ok_q <= ack_ok_d;
			prim_q <= prim_d;
			sec_q <= sec_d;
			wd_q <= wd_d;
			sda_o_q <= 1'b0;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign SDA_O = sda_o_q;
	assign SDA_OE = oe_q;
	assign WATCHDOG_RESTART = wd_q;
	assign CHARGER_ENABLE = prim_q[pmic_regs_pkg::CHGEN_BIT];
	assign CHARGE_TIMERS_ENABLE = prim_q[pmic_regs_pkg::TIMERS_BIT];
	assign THERMISTOR_CONTROL_ENABLE = prim_q[pmic_regs_pkg::THERM_BIT];
	assign CHARGER_CONTROL_SECONDARY = sec_q;

	// ***************************************************
	// assertions
	// ***************************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	a_wo_reads_zero: assert property (
		ptr_q == pmic_regs_pkg::ADDR_TOP_WO |-> rdata == 8'h00)
		else $error("write-only register read back nonzero");
	a_wd_restart: assert property (
		wr_fire && ptr_q == pmic_regs_pkg::ADDR_TOP_WO && sh_q[2:0] == 3'h1
		|=> WATCHDOG_RESTART ##1 !WATCHDOG_RESTART || !CE)
		else $error("watchdog restart pulse missing");
	a_wd_quiet: assert property (
		CE && !(wr_fire && ptr_q == pmic_regs_pkg::ADDR_TOP_WO
		&& sh_q[2:0] == 3'h1) |=> !WATCHDOG_RESTART)
		else $error("watchdog restarted without code 001");
	a_lock_open: assert property (
		wr_fire && ptr_q == pmic_regs_pkg::ADDR_CHG_SEC && prim_q[7:3] == 5'h15
		|=> sec_q == $past(sh_q))
		else $error("unlocked write not taken");
	a_lock_hold: assert property (
		wr_fire && ptr_q == pmic_regs_pkg::ADDR_CHG_SEC && prim_q[7:3] != 5'h15
		|=> $stable(sec_q))
		else $error("locked register changed");
	a_key_write: assert property (
		wr_fire && ptr_q == pmic_regs_pkg::ADDR_CHG_PRI
		|=> prim_q == $past(sh_q))
		else $error("key register write lost");
	a_prim_readback: assert property (
		CE && scl_fall && state_q == pmic_regs_pkg::S_ACK
		&& nxt_q == pmic_regs_pkg::S_RD && ptr_q == pmic_regs_pkg::ADDR_CHG_PRI
		|=> tx_q == $past(prim_q))
		else $error("primary register readback mismatch");
	a_therm_reset: assert property (
		$past(SRST) |-> !THERMISTOR_CONTROL_ENABLE)
		else $error("thermistor enable not reset to 0");
	a_timer_reset: assert property (
		$past(SRST) |-> CHARGE_TIMERS_ENABLE)
		else $error("timer enable not reset to 1");
	a_chg_strap: assert property (
		$past(SRST) |-> CHARGER_ENABLE == $past(CHARGER_ENABLE_DEFAULT))
		else $error("charger enable not loaded from default");
	a_sec_reset: assert property (
		$past(SRST) |-> CHARGER_CONTROL_SECONDARY == pmic_regs_pkg::SEC_RESET)
		else $error("secondary register reset value wrong");

	c_wd_restart: cover property (WATCHDOG_RESTART);
	c_sec_unlocked: cover property (
		wr_fire && ptr_q == pmic_regs_pkg::ADDR_CHG_SEC && key_open);
	c_sec_locked: cover property (
		wr_fire && ptr_q == pmic_regs_pkg::ADDR_CHG_SEC && !key_open);
	c_read: cover property (state_q == pmic_regs_pkg::S_MACK ##1 ack_ok_q);

endmodule : pmic_watchdog_charger_ctrl_regs

// ### i2c_host.sv
`timescale 1ns/1ns
module i2c_host (
	// clock
	input wire logic clk,
	// bus lines
	input wire logic sda,
	output logic scl,
	output logic sda_low,
	// observed results
	output logic res_valid,
	output logic [7:0] res_data
);
	logic ack;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		res_valid = 1'b0;
		res_data = 8'h00;
		ack = 1'b1;
	end
	// ************
	// bus phases, six clocks per half bit
	// ************
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	task automatic put(input logic c, input logic low);
		scl <= c;
		sda_low <= low;
		hold(6);
	endtask : put
	// data moves only while the clock line is low
	task automatic shift_low(input logic low);
		scl <= 1'b0;
		hold(3);
		sda_low <= low;
		hold(3);
	endtask : shift_low
	task automatic start;
		shift_low(1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
	endtask : start
	task automatic stop;
		shift_low(1'b1);
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
	endtask : stop
	task automatic bit_io(input logic b, output logic s);
		shift_low(!b);
		put(1'b1, !b);
		s = sda;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] v, output logic [7:0] r);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], s);
			r[i] = s;
		end
	endtask : byte_io
	// byte, then the device's acknowledge
	task automatic send(input logic [7:0] v);
		logic [7:0] r;
		logic s;
		byte_io(v, r);
		bit_io(1'b1, s);
		ack = ack & !s;
	endtask : send
	task automatic post(input logic [7:0] v);
		res_data <= v;
		res_valid <= 1'b1;
		@(posedge clk);
		res_valid <= 1'b0;
	endtask : post
	// ************
	// transfers
	// ************
	task automatic wr(input logic [6:0] dev, input logic [7:0] a,
		input logic [7:0] d);
		ack = 1'b1;
		start;
		send({dev, 1'b0});
		send(a);
		send(d);
		stop;
		post({7'h00, ack});
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic [7:0] r;
		logic s;
		start;
		send({pmic_regs_pkg::DEV_ADDR, 1'b0});
		send(a);
		start;
		send({pmic_regs_pkg::DEV_ADDR, 1'b1});
		byte_io(8'hFF, r);
		bit_io(1'b1, s);
		stop;
		post(r);
	endtask : rd
endmodule : i2c_host

// ### pmic_watchdog_charger_ctrl_regs_bench.sv
`timescale 1ns/1ns
module pmic_watchdog_charger_ctrl_regs_bench;
	logic clk = 1'b0;
	logic srst, ce, chg_def, scl, sda_low, res_valid, sda_o, sda_oe, wd;
	logic charger_enable, tmr_en, th_en, sda_w;
	logic [7:0] res_data, sec, sec_exp, r;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int cmp_count = 0;
	int wd_count = 0;
	int n;
	integer seed = 32'h4EE4ED86;
	always #20 clk = ~clk;
	// open-drain data line with pull-up
	assign sda_w = !(sda_low || (sda_oe && !sda_o));
	pmic_watchdog_charger_ctrl_regs dut (
		.CLK_SYS(clk), .SRST(srst), .CE(ce), .SCL_I(scl), .SDA_I(sda_w),
		.SDA_O(sda_o), .SDA_OE(sda_oe), .CHARGER_ENABLE_DEFAULT(chg_def),
		.WATCHDOG_RESTART(wd), .CHARGER_ENABLE(charger_enable),
		.CHARGE_TIMERS_ENABLE(tmr_en), .THERMISTOR_CONTROL_ENABLE(th_en),
		.CHARGER_CONTROL_SECONDARY(sec)
	);
	i2c_host host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low),
		.res_valid(res_valid), .res_data(res_data));
	// ************
	// checking
	// ************
	task automatic note(input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask : note
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
		note(e, g);
	endtask : cmp_byte
	task automatic cmp_pin(input logic [7:0] e, input logic [7:0] g);
		note(e, g);
	endtask : cmp_pin
	always @(posedge clk) begin
		if (res_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("mismatch at %0t: expected none got %h", $time, res_data);
			end else begin
				cmp_byte(exp_q.pop_front(), res_data);
			end
		end
	end
	always @(posedge clk) begin
		if (wd === 1'b1) begin
			wd_count++;
		end
	end
	task automatic tally_and_finish;
		num_errors += exp_q.size();
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	// ************
	// stimulus
	// ************
	task automatic do_reset(input logic def);
		srst <= 1'b1;
		chg_def <= def;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		sec_exp = pmic_regs_pkg::SEC_RESET;
	endtask : do_reset
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		exp_q.push_back(8'h01);
		host.wr(pmic_regs_pkg::DEV_ADDR, a, d);
	endtask : w
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask : rdx
	task automatic check_pins(input logic [7:0] p);
		cmp_pin(p, {5'h00, th_en, tmr_en, charger_enable});
		cmp_pin(sec_exp, sec);
	endtask : check_pins
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		chg_def = 1'b1;
		do_reset(1'b1);
		check_pins(8'h03);
		rdx(pmic_regs_pkg::ADDR_CHG_PRI, 8'h03);
		rdx(pmic_regs_pkg::ADDR_CHG_SEC, sec_exp);
		for (int c = 0; c < 8; c++) begin
			n = wd_count;
			r = 8'($random(seed));
			w(pmic_regs_pkg::ADDR_TOP_WO, {r[7:3], 3'(c)});
			cmp_pin({7'h00, 3'(c) == pmic_regs_pkg::WD_RESTART_CODE},
				8'(wd_count - n));
		end
		rdx(pmic_regs_pkg::ADDR_TOP_WO, pmic_regs_pkg::READ_ZERO);
		r = 8'($random(seed)) & 8'h3F;
		w(pmic_regs_pkg::ADDR_CHG_SEC, r);
		rdx(pmic_regs_pkg::ADDR_CHG_SEC, sec_exp);
		w(pmic_regs_pkg::ADDR_CHG_PRI, 8'hAC);
		check_pins(8'h04);
		rdx(pmic_regs_pkg::ADDR_CHG_PRI, 8'hAC);
		w(pmic_regs_pkg::ADDR_CHG_SEC, r);
		sec_exp = r;
		rdx(pmic_regs_pkg::ADDR_CHG_SEC, sec_exp);
		w(pmic_regs_pkg::ADDR_CHG_PRI, 8'h53);
		w(pmic_regs_pkg::ADDR_CHG_SEC, ~r & 8'h3F);
		rdx(pmic_regs_pkg::ADDR_CHG_SEC, sec_exp);
		check_pins(8'h03);
		exp_q.push_back(8'h00);
		host.wr(pmic_regs_pkg::DEV_ADDR ^ 7'h01, 8'h10, 8'hFF);
		rdx(pmic_regs_pkg::ADDR_CHG_PRI, 8'h53);
		do_reset(1'b0);
		check_pins(8'h02);
		rdx(pmic_regs_pkg::ADDR_CHG_PRI, pmic_regs_pkg::PRI_RESET);
		// a frozen block must neither answer nor store
		ce <= 1'b0;
		exp_q.push_back(8'h00);
		host.wr(pmic_regs_pkg::DEV_ADDR, pmic_regs_pkg::ADDR_CHG_PRI, 8'hAC);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		rdx(pmic_regs_pkg::ADDR_CHG_PRI, pmic_regs_pkg::PRI_RESET);
		check_pins(8'h02);
		// let the checker take the last result
		repeat (2) @(posedge clk);
		tally_and_finish;
	end
endmodule : pmic_watchdog_charger_ctrl_regs_bench
